/* File: common/mib_defs.svh */
/*
 * constants of the microinstruction bus decoder: opcodes, field positions,
 * bus geometry and phase timing.
 * assumes a 20 MHz mclk_in; included by bare name.
 */
`ifndef MIB_DEFS_SVH
`define MIB_DEFS_SVH

`define MIB_LINES 22
`define SYNC_W 24
`define JUMP_LINE 15
`define REPLY_BIT 22
`define IRQ_BIT 23

`define OP_MSB 15
`define OP_LSB 8
`define SRC_MSB 7
`define SRC_LSB 4
`define DST_MSB 3
`define DST_LSB 0
`define CSEL_MSB 11
`define CSEL_LSB 9
`define CSENSE_BIT 8

`define JMP_NIBBLE 4'h1
`define OP_OUT_BYTE 8'hfc
`define OP_OUT_WORD 8'hfd
`define OP_OUT_STAT 8'hfe
`define OP_NOP 8'hff

`define CLK_NS 50
`define PHASE_NS 200
`define PHASE_CYC (`PHASE_NS / `CLK_NS)

`define RF_RESET 8'h00
`define FLAGS_RESET 8'h00

`endif

/* File: common/mib_pkg.sv */
/*
 * types shared by the decoder and its phase sequencer.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package mib_pkg;
  typedef enum logic [1:0] {
    PH1 = 2'b00,
    PH2 = 2'b01,
    PH3 = 2'b10,
    PH4 = 2'b11
  } phase_e;

  typedef struct packed {
    logic nb;
    logic zb;
    logic c4;
    logic c8;
    logic n;
    logic z;
    logic v;
    logic c;
  } flags_s;

  typedef struct packed {
    logic [21:0] dat;
    logic [21:0] oe;
  } mib_drv_s;

  typedef struct packed {
    logic oe;
    logic dout;
    logic [15:0] data;
  } dal_s;
endpackage

/* File: rtl/phase_seq.sv */
/*
 * four-phase sequencer: each phase lasts PHASE_CYC clocks.
 * assumes an active-low reset from the parent, released in step with clk_in.
 */
`timescale 1ns/1ps
`include "mib_defs.svh"
module phase_seq
  import mib_pkg::*;
#(
  parameter int PHASE_CYC = `PHASE_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  output phase_e ph_out,
  output logic last_out
);
  typedef struct packed {
    logic [7:0] cnt;
    phase_e ph;
  } seq_s;

  seq_s q;
  seq_s n;

  always_comb begin
    n = q;
    if (q.cnt == 8'(PHASE_CYC - 1)) begin
      n.cnt = 8'h00;
      n.ph = phase_e'(q.ph + 2'h1);
    end else begin
      n.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '{cnt: 8'h00, ph: PH1};
    end else begin
      q <= n;
    end
  end

  assign ph_out = q.ph;
  assign last_out = (q.cnt == 8'(PHASE_CYC - 1));
endmodule

/* File: rtl/mib_decoder.sv */
/*
 * data-side microinstruction decoder on the precharged four-phase bus.
 * assumes the ROMs precharge the bus and drive each instruction from the
 * start of phase one; bus pins and reply/irq arrive asynchronously.
 */
// Contract
// - output byte drives pair, strobe, waits reply
// - output word drives pair, strobe, waits reply
// - output status: one cycle, no strobe, no wait
// - all-ones opcode is one-cycle no-op
// - conditional jump fields; odd true; two cycles
// - register format: opcode, source, destination fields
// - status and condition flags updated per opcode
// - bus has twenty-two shared lines
// - signal only by pulling precharged lines low
// - bus data carried in complement form
// - four-phase clocked bidirectional bus
// - line meaning depends on current phase
// - phase four: pull jump line when met
// - control chip owns bus in phases two-three
`timescale 1ns/1ps
`include "mib_defs.svh"
module mib_decoder
  import mib_pkg::*;
#(
  parameter int PHASE_CYC = `PHASE_CYC
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic [21:0] mib_in,
  input wire logic reply_in,
  input wire logic irq_in,
  output mib_drv_s mib_drv_out,
  output dal_s dal_out,
  output logic stall_out,
  output phase_e phase_out,
  output flags_s flags_out
);
  typedef struct packed {
    logic [`SYNC_W-1:0] s1;
    logic [`SYNC_W-1:0] s2;
    logic [`SYNC_W-1:0] s3;
    logic [`SYNC_W-1:0] filt;
    logic [15:0][7:0] rf;
    flags_s flags;
    logic [15:0] ir;
    logic busy;
    logic cyc2;
    logic got;
    mib_drv_s drv;
    dal_s dal;
    logic stall;
    phase_e ph;
  } st_s;

  st_s q;
  st_s n;
  logic [1:0] rst_sync_r;
  logic rst_n;
  phase_e ph;
  logic last;

  assign rst_n = rst_sync_r[1];

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  phase_seq #(
    .PHASE_CYC(PHASE_CYC)
  ) u_seq (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .ph_out(ph),
    .last_out(last)
  );

  function automatic logic is_jump(input logic [15:0] w);
    is_jump = (w[15:12] == `JMP_NIBBLE);
  endfunction

  // word forms of the 80-ef register group take a second microcycle
  function automatic logic two_cycle(input logic [15:0] w);
    logic [7:0] op;
    op = w[`OP_MSB:`OP_LSB];
    two_cycle = is_jump(w) || (op >= 8'h80 && op <= 8'hef && op[1]);
  endfunction

  function automatic logic is_out(input logic [7:0] op);
    is_out = (op == `OP_OUT_BYTE) || (op == `OP_OUT_WORD);
  endfunction

  // upper select bits pick the flag, the low bit picks the sense
  function automatic logic cond_met(input logic [15:0] w, input flags_s f,
                                    input logic irq);
    logic t;
    t = 1'b0;
    case (w[`CSEL_MSB:`CSEL_LSB])
      3'h0: t = f.zb;
      3'h1: t = f.c8;
      3'h2: t = irq;
      3'h3: t = f.nb;
      3'h4: t = f.z;
      3'h5: t = f.c;
      3'h6: t = f.v;
      default: t = f.n;
    endcase
    cond_met = (t == w[`CSENSE_BIT]);
  endfunction

  logic [7:0] op;
  logic [3:0] sa;
  logic [3:0] da;
  logic [15:0] bw;
  logic [15:0] aw;
  logic [15:0] res;
  logic wr;
  logic logic_cls;
  logic oc_cls;
  logic word;
  logic hit;
  logic fin;

  // register-format fields
  assign op = q.ir[`OP_MSB:`OP_LSB];
  assign sa = q.ir[`SRC_MSB:`SRC_LSB];
  assign da = q.ir[`DST_MSB:`DST_LSB];
  assign bw = {q.rf[4'(sa + 4'h1)], q.rf[sa]};
  assign aw = {q.rf[4'(da + 4'h1)], q.rf[da]};
  assign word = op[1];
  assign hit = q.busy && is_jump(q.ir) && cond_met(q.ir, q.flags, q.filt[`IRQ_BIT]);
  assign fin = q.busy && ph == PH4 && last && !(two_cycle(q.ir) && !q.cyc2) &&
               !(is_out(op) && !q.got && !q.filt[`REPLY_BIT]);

  always_comb begin
    res = 16'h0000;
    wr = 1'b1;
    logic_cls = 1'b1;
    oc_cls = 1'b0;
    case (op[7:2])
      6'h20: res = bw;
      6'h21: res = ~bw;
      6'h27: begin
        res = ~bw;
        logic_cls = 1'b0;
        oc_cls = 1'b1;
      end
      6'h30: res = bw & aw;
      6'h31: begin
        res = bw & aw;
        wr = 1'b0;
      end
      6'h32: res = bw | aw;
      6'h33: res = bw ^ aw;
      6'h34: res = ~bw & aw;
      default: begin // other ops and the no-op write nothing
        wr = 1'b0;
        logic_cls = 1'b0;
      end
    endcase
    if (is_jump(q.ir)) begin
      wr = 1'b0;
      logic_cls = 1'b0;
    end
  end

  always_comb begin
    n = q;
    n.s1 = {irq_in, reply_in, mib_in}; // all shared lines sensed
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.filt = (q.s2 & q.s3) | (q.filt & (q.s2 ^ q.s3));
    n.ph = ph;
    n.drv.dat = '0;
    n.drv.oe = '0;
    // only phase one is read; two-three carry the control-chip address
    // fetch only on a free microcycle; a discharged line reads as one
    if (ph == PH1 && last && !q.busy) begin
      n.ir = ~q.filt[15:0];
      n.busy = 1'b1;
      n.cyc2 = 1'b0;
      n.got = 1'b0;
    end
    // jump result by discharge only, aligned to phase four
    if (hit && !q.cyc2 && ((ph == PH3 && last) || (ph == PH4 && !last))) begin
      n.drv.oe[`JUMP_LINE] = 1'b1;
    end
    if (q.busy && ph == PH2 && (is_out(op) || op == `OP_OUT_STAT)) begin
      n.dal.oe = 1'b1;
      n.dal.data = {q.rf[sa], q.rf[da]};
      n.dal.dout = is_out(op);
    end
    if (q.dal.dout && q.filt[`REPLY_BIT]) begin
      n.got = 1'b1;
    end
    // two-cycle words and unanswered outputs hold the decoder
    if (q.busy && ph == PH4 && last && !fin) begin
      n.cyc2 = 1'b1;
      n.stall = is_out(op);
    end
    if (fin) begin
      n.busy = 1'b0;
      n.stall = 1'b0;
      n.dal.oe = 1'b0;
      n.dal.dout = 1'b0;
      // status output ends here whatever reply does
      if (wr) begin // byte forms write the named destination, word forms also the next register
        n.rf[da] = res[7:0];
        if (word) begin
          n.rf[4'(da + 4'h1)] = res[15:8];
        end
      end
      if (logic_cls || oc_cls) begin
        n.flags.nb = res[7];
        n.flags.zb = (res[7:0] == 8'h00);
        if (op[0]) begin
          n.flags.n = word ? res[15] : res[7];
          n.flags.z = word ? (res == 16'h0000) : (res[7:0] == 8'h00);
          n.flags.v = 1'b0;
        end
      end
      // ones-complement clears both carries; only the odd form sets c
      if (oc_cls) begin
        n.flags.c4 = 1'b0;
        n.flags.c8 = 1'b0;
        if (op[0]) begin
          n.flags.c = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.rf <= {16{`RF_RESET}};
      q.flags <= `FLAGS_RESET;
      q.ph <= PH1;
    end else begin
      q <= n;
    end
  end

  assign mib_drv_out = q.drv;
  assign dal_out = q.dal;
  assign stall_out = q.stall;
  assign phase_out = q.ph;
  assign flags_out = q.flags;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  a_jump_in_ph4: assert property (q.drv.oe[`JUMP_LINE] |-> ph == PH4)
    else $error("jump line discharged outside phase four");
  a_no_high_drive: assert property (q.drv.dat == '0 && q.drv.oe[21:16] == '0 &&
    (q.drv.oe == '0 || ph == PH4))
    else $error("bus driven high or outside phase four");
  a_status_no_dout: assert property (q.dal.oe && op == `OP_OUT_STAT |-> !q.dal.dout)
    else $error("status output raised the data-out strobe");
  a_out_waits: assert property (q.dal.dout && !q.got && !q.filt[`REPLY_BIT]
    |=> q.dal.dout)
    else $error("output dropped strobe before reply");
  a_nop_quiet: assert property (fin && op == `OP_NOP |=> $stable(q.flags) && $stable(q.rf))
    else $error("no-op changed state");
  a_jump_flags: assert property (fin && is_jump(q.ir) |=> $stable(q.flags))
    else $error("jump changed flags");
  a_two_cycles: assert property (q.busy && ph == PH4 && last && two_cycle(q.ir) &&
    !q.cyc2 |=> q.busy && q.cyc2)
    else $error("two-cycle op ended after one microcycle");
  a_out_regs_kept: assert property (fin && (is_out(op) || op == `OP_OUT_STAT)
    |=> $stable(q.rf))
    else $error("output op modified registers");
  a_ones_comp: assert property (fin && op[7:2] == 6'h27 && op[0]
    |=> q.flags.c && !q.flags.v && !q.flags.c4 && !q.flags.c8)
    else $error("ones complement flags wrong");
endmodule

/* File: bench/mib_partner.sv */
/*
 * far side of the decoder: microcode rom, control chip address, output unit.
 * assumes phase_in is the decoder's own phase output.
 */
`timescale 1ns/1ps
module mib_partner
  import mib_pkg::*;
(
  input wire logic mclk_in,
  input phase_e phase_in,
  input wire logic [15:0] word_in,
  input wire logic [21:0] dev_oe_in,
  input wire logic dout_in,
  input wire logic [7:0] dly_in,
  output logic [21:0] mib_out,
  output logic reply_out
);
  logic [7:0] cnt_r = 8'h00;
  logic [10:0] addr_r = 11'h000;
  logic [21:0] dis;
  // precharged lines, parties only discharge; low line is a one
  always_comb begin
    dis = dev_oe_in;
    if (phase_in == PH1) begin
      dis = dis | {6'h00, word_in};
    end else if (phase_in != PH4) begin
      dis[10:0] = dis[10:0] | addr_r;
    end
    mib_out = ~dis;
  end
  // address pattern keeps moving so a stray sample is seen
  always @(posedge mclk_in) begin
    addr_r <= addr_r + 11'h25b;
    if (!dout_in) begin
      cnt_r <= 8'h00;
      reply_out <= 1'b0;
    end else if (cnt_r == dly_in) begin
      reply_out <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  initial reply_out = 1'b0;
endmodule

/* File: bench/testbench.sv */
/*
 * self-checking bench of the microinstruction decoder.
 * assumes the far side model mib_partner and the shared package.
 */
`timescale 1ns/1ps
module testbench import mib_pkg::*; ;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic irq_in = 1'b0;
  logic [15:0] rom_w = 16'hffff;
  logic [7:0] dly = 8'h02;
  logic [21:0] mib_in;
  logic reply_in, stall_out, s_stall, s_j;
  mib_drv_s mib_drv_out;
  dal_s dal_out, s_dal;
  phase_e phase_out;
  flags_s flags_out, ef;
  logic [7:0] regs [16];
  logic [7:0] ops [8] = '{8'h80, 8'h9c, 8'hc0, 8'hc4, 8'hc8, 8'hcc, 8'hd0, 8'h84};
  logic [31:0] seed = 32'h1d7c;
  int n_errors = 0;
  int check_count = 0;

  initial forever #25 mclk_in = ~mclk_in;

  mib_decoder #(.PHASE_CYC(8)) mib_decoder_i (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .mib_in(mib_in), .reply_in(reply_in), .irq_in(irq_in), .mib_drv_out(mib_drv_out),
    .dal_out(dal_out), .stall_out(stall_out), .phase_out(phase_out), .flags_out(flags_out));
  mib_partner mib_partner_i (.mclk_in(mclk_in), .phase_in(phase_out), .word_in(rom_w),
    .dev_oe_in(mib_drv_out.oe), .dout_in(dal_out.dout), .dly_in(dly), .mib_out(mib_in),
    .reply_out(reply_in));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic jump_exp(input logic [3:0] s);
    logic [7:0] c;
    c = {ef.n, ef.v, ef.c, ef.z, ef.nb, irq_in, ef.c8, ef.zb};
    return c[s[3:1]] == s[0];
  endfunction

  function automatic void model(input logic [7:0] op, input logic [3:0] b, input logic [3:0] a);
    logic [7:0] r;
    r = ~regs[b] & regs[a];
    case (op[7:1])
      7'h40: r = regs[b];
      7'h42: r = ~regs[b];
      7'h4e: r = ~regs[b];
      7'h60, 7'h62: r = regs[b] & regs[a];
      7'h64: r = regs[b] | regs[a];
      7'h66: r = regs[b] ^ regs[a];
      default: r = r;
    endcase
    // test form leaves its destination alone
    if (op[7:1] != 7'h62) regs[a] = r;
    ef.nb = r[7];
    ef.zb = (r == 8'h00);
    if (op[7:1] == 7'h4e) begin
      ef.c4 = 1'b0;
      ef.c8 = 1'b0;
    end
    if (op[0]) begin
      ef.n = r[7];
      ef.z = (r == 8'h00);
      ef.v = 1'b0;
      if (op[7:1] == 7'h4e) ef.c = 1'b1;
    end
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wait_ph(input phase_e p);
    int i;
    for (i = 0; i < 100 && phase_out !== p; i++) @(negedge mclk_in);
    if (phase_out !== p) begin
      n_errors++;
      final_report();
    end
  endtask

  // one instruction; samples the bus side two clocks into its first phase four
  task automatic exec(input logic [15:0] w, input int cyc);
    int i;
    wait_ph(PH4);
    rom_w = w;
    wait_ph(PH1);
    wait_ph(PH2);
    rom_w = 16'hffff;
    wait_ph(PH4);
    repeat (2) @(negedge mclk_in);
    s_dal = dal_out;
    s_j = mib_drv_out.oe[15];
    chk("bus drive level", mib_drv_out.dat, 0);
    wait_ph(PH1);
    for (i = 1; i < cyc; i++) begin
      wait_ph(PH4);
      wait_ph(PH1);
    end
    repeat (2) @(negedge mclk_in);
    s_stall = stall_out;
    for (i = 0; i < 400 && stall_out !== 1'b0; i++) @(negedge mclk_in);
    if (stall_out !== 1'b0) begin
      n_errors++;
      final_report();
    end
    @(negedge mclk_in);
    chk("dal release", dal_out.oe, 0);
  endtask

  task automatic op_run(input logic [7:0] op, input logic [3:0] b, input logic [3:0] a);
    exec({op, b, a}, 1);
    model(op, b, a);
    chk("flags", flags_out, ef);
  endtask

  task automatic os_run(input logic [3:0] b, input logic [3:0] a);
    exec({8'hfe, b, a}, 1);
    chk("status dal", s_dal, {2'b10, regs[b], regs[a]});
    chk("status stall", s_stall, 0);
    chk("status flags", flags_out, ef);
  endtask

  initial begin
    int i;
    for (i = 0; i < 16; i++) regs[i] = 8'h00;
    ef = '0;
    repeat (5) @(negedge mclk_in);
    arst_n_in = 1'b1;
    chk("reset flags", flags_out, 0);
    chk("reset dal", dal_out, 0);
    exec(16'hff00, 1);
    chk("nop flags", flags_out, ef);
    wait_ph(PH2);
    wait_ph(PH3);
    for (i = 0; i < 40 && phase_out !== PH4; i++) @(negedge mclk_in);
    chk("phase length", i, 8);
    op_run(8'h9d, 4'h0, 4'h1);
    $display("test reset_nop done");
    for (i = 0; i < 16; i++) begin
      exec({4'h1, i[3:0], 8'h5a}, 2);
      chk("jump line", s_j, jump_exp(i[3:0]));
      chk("jump flags", flags_out, ef);
      irq_in = ~irq_in;
    end
    $display("test jumps done");
    for (i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      irq_in = seed[8];
      if (!seed[10]) op_run(ops[seed[14:12]] | {7'h00, seed[15]}, seed[7:4], seed[3:0]);
      else if (seed[9]) os_run(seed[7:4], seed[3:0]);
      else begin
        exec({4'h1, seed[7:4], seed[7:0]}, 2);
        chk("jump line", s_j, jump_exp(seed[7:4]));
      end
    end
    $display("test random done");
    exec(16'h8324, 2);
    regs[4] = regs[2];
    regs[5] = regs[3];
    ef.nb = regs[4][7];
    ef.zb = (regs[4] == 8'h00);
    ef.n = regs[5][7];
    ef.z = ({regs[5], regs[4]} == 16'h0000);
    ef.v = 1'b0;
    chk("word move flags", flags_out, ef);
    dly = 8'h3c;
    exec(16'hfd21, 1);
    chk("word dal", s_dal, {2'b11, regs[2], regs[1]});
    chk("word stall", s_stall, 1);
    dly = 8'h02;
    exec(16'hfc33, 1); // same register in both fields
    chk("byte dal", s_dal, {2'b11, regs[3], regs[3]});
    chk("byte stall", s_stall, 0);
    chk("out flags", flags_out, ef);
    os_run(4'h4, 4'h5);
    $display("test outputs done");
    final_report();
  end
endmodule
